// >>> common/tamper_consts.vh
`ifndef TAMPER_CONSTS_VH
`define TAMPER_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define TAMP_CSR_OFFSET 12'h000
`define TAMP_DATA_BASE 12'h004
`define TAMP_DATA_WORDS 10
`define TAMP_DATA_AW 4
`define TAMP_DATA_DW 16

// ----------------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------------
`define TAMP_EVENT_CLEAR_BIT 0
`define TAMP_IRQ_CLEAR_BIT 1
`define TAMP_IRQ_ENABLE_BIT 2
`define TAMP_EVENT_FLAG_BIT 8
`define TAMP_IRQ_FLAG_BIT 9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TAMP_CSR_RESET 32'h00000000
`define TAMP_DATA_RESET 16'h0000

// ----------------------------------------------------------------------
// Timing: wait cycles in the access phase before ready
// ----------------------------------------------------------------------
`define TAMP_APB_WAIT 2

`endif

// >>> dv/tamper_status_control_sva.sv
`include "tamper_consts.vh"

module tamper_status_control_sva (
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB slave side
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Tamper and power state
	input wire tamper_detect,
	input wire standby_wake,
	input wire core_sleep,
	input wire tamper_irq_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// -----
	// Transfer steps
	// -----
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	// Completing edges of a CSR read and of an irq-clear write
	wire done = psel && penable && pready;
	wire csr_rd = done && !pwrite && paddr == `TAMP_CSR_OFFSET;
	wire icl_wr = done && pwrite && paddr == `TAMP_CSR_OFFSET && pwdata[1];

	// -----
	// Checks
	// -----
	a_two_waits: assert property (setup_s ##1 access_s |->
		!pready ##1 !pready ##1 pready)
		else $error("ready not after two wait states");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside a completing access");
	a_rdata_quiet: assert property (!(done && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside a read answer");
	a_evclr_zero: assert property (csr_rd |-> !prdata[0])
		else $error("event clear bit reads one");
	a_irqclr_zero: assert property (csr_rd |-> !prdata[1])
		else $error("irq clear bit reads one");
	a_resv_zero: assert property (csr_rd |-> prdata[7:3] == 5'h00)
		else $error("reserved bits not zero");
	a_sleep_mask: assert property (core_sleep |=> !tamper_irq_r)
		else $error("irq shown while core sleeps");
	a_irq_cleared: assert property (icl_wr |=> !tamper_irq_r)
		else $error("irq still high after clear");
endmodule

bind tamper_status_control tamper_status_control_sva
	u_tamper_status_control_sva (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tamper_detect(tamper_detect), .standby_wake(standby_wake),
	.core_sleep(core_sleep), .tamper_irq_r(tamper_irq_r));

// >>> dv/tb_tamper_status_control.sv
`include "tamper_consts.vh"

module tb_tamper_status_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, tamper_detect = 1'h0;
	logic standby_wake = 1'h0, core_sleep = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic er;
	wire [31:0] prdata;
	wire pready, pslverr, tamper_irq_r;
	int fail_count = 0, compares = 0, cyc = 0;
	localparam logic [11:0] CSR = `TAMP_CSR_OFFSET;

	// Clock enable held high: freezing is not exercised here
	tamper_status_control u_tamper_status_control (
		.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tamper_detect(tamper_detect),
		.standby_wake(standby_wake), .core_sleep(core_sleep),
		.tamper_irq_r(tamper_irq_r));

	// -----
	// Clock, timeout, helpers
	// -----
	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic close_out();
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	// One APB transfer; request held until ready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only ready or the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rchk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	function automatic logic [11:0] wa(input int i);
		return `TAMP_DATA_BASE + 12'(4 * i);
	endfunction
	// Fresh rising edge on the pin; margin covers the synchroniser
	task automatic hit();
		@(posedge pclk);
		tamper_detect <= 1'h0;
		repeat (4) @(posedge pclk);
		tamper_detect <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask

	// -----
	// Main sequence
	// -----
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		rchk("csr", CSR, `TAMP_CSR_RESET);
		// Data words: reset value, write, read back in 15:0
		for (int i = 0; i < `TAMP_DATA_WORDS; i++) begin
			rchk("word", wa(i), 32'h0);
			xfer(1'h1, wa(i), {16'hA5A5, 16'h1230 + 16'(i)});
			rchk("word", wa(i), {16'h0000, 16'h1230 + 16'(i)});
		end
		xfer(1'h0, 12'h100, 32'h0);
		chk("err", {31'h0, er}, 32'h1);
		chk("rdata", rd, 32'h0);
		// All ones: only the enable sticks
		xfer(1'h1, CSR, 32'hFFFFFFFF);
		rchk("csr", CSR, 32'h4);
		hit();
		chk("irq", {31'h0, tamper_irq_r}, 32'h1);
		rchk("csr", CSR, 32'h304);
		xfer(1'h1, wa(3), 32'h00001234);
		xfer(1'h1, CSR, 32'h304);
		rchk("csr", CSR, 32'h304);
		// Sleeping core hides the irq but not its flag
		@(posedge pclk);
		core_sleep <= 1'h1;
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, tamper_irq_r}, 32'h0);
		rchk("csr", CSR, 32'h304);
		core_sleep <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, tamper_irq_r}, 32'h1);
		xfer(1'h1, CSR, 32'h6);
		rchk("csr", CSR, 32'h104);
		chk("irq", {31'h0, tamper_irq_r}, 32'h0);
		// Pin still high: no second event after the clear
		xfer(1'h1, CSR, 32'h5);
		repeat (8) @(posedge pclk);
		rchk("csr", CSR, 32'h4);
		rchk("word", wa(0), 32'h0);
		rchk("word", wa(3), 32'h0);
		hit();
		rchk("csr", CSR, 32'h304);
		// Wake drops enable and irq flag, keeps the event flag
		@(posedge pclk);
		standby_wake <= 1'h1;
		repeat (4) @(posedge pclk);
		standby_wake <= 1'h0;
		repeat (4) @(posedge pclk);
		rchk("csr", CSR, 32'h100);
		// Event with enable low leaves the irq alone
		xfer(1'h1, CSR, 32'h1);
		hit();
		rchk("csr", CSR, 32'h100);
		chk("irq", {31'h0, tamper_irq_r}, 32'h0);
		xfer(1'h1, CSR, 32'h1);
		xfer(1'h1, wa(9), 32'h0000BEEF);
		rchk("word", wa(9), 32'h0000BEEF);
		close_out();
	end
endmodule

// >>> hw/backup_data_mem.v
`include "tamper_consts.vh"

module backup_data_mem (
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// Hold in reset
	input wire clr,
	// Write port
	input wire wr_en,
	input wire [`TAMP_DATA_AW-1:0] wr_addr,
	input wire [`TAMP_DATA_DW-1:0] wr_data,
	// Read port, data from a register
	input wire [`TAMP_DATA_AW-1:0] rd_addr,
	output reg [`TAMP_DATA_DW-1:0] rd_data_r
);

	reg [`TAMP_DATA_DW-1:0] mem_r [0:`TAMP_DATA_WORDS-1];
	genvar gi;

	// ------------------------------------------------------------------
	// Storage words
	// ------------------------------------------------------------------
	generate
		for (gi = 0; gi < `TAMP_DATA_WORDS; gi = gi + 1) begin : g_word
			// Clear wins over any write so a tamper leaves no trace
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem_r[gi] <= `TAMP_DATA_RESET;
				end else if (ce) begin
					if (clr) begin
						mem_r[gi] <= `TAMP_DATA_RESET;
					end else if (wr_en && wr_addr == gi) begin
						mem_r[gi] <= wr_data;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Registered read
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_r <= `TAMP_DATA_RESET;
		end else if (ce) begin
			if (clr || rd_addr >= `TAMP_DATA_WORDS) begin
				rd_data_r <= `TAMP_DATA_RESET;
			end else begin
				rd_data_r <= mem_r[rd_addr];
			end
		end
	end

endmodule

// >>> hw/tamper_status_control.v
`include "tamper_consts.vh"


module tamper_status_control (
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Tamper detection and power state
	input wire tamper_detect,
	input wire standby_wake,
	input wire core_sleep,
	// Interrupt towards the core
	output reg tamper_irq_r
);

	// ------------------------------------------------------------------
	// Address decode helpers
	// ------------------------------------------------------------------
	function is_data;
		input [11:0] a;
		begin
			is_data = (a[1:0] == 2'h0) && (a >= `TAMP_DATA_BASE) &&
				(a < `TAMP_DATA_BASE + 4 * `TAMP_DATA_WORDS);
		end
	endfunction

	function [`TAMP_DATA_AW-1:0] data_index;
		input [11:0] a;
		reg [11:0] d;
		begin
			d = a - `TAMP_DATA_BASE;
			data_index = d[`TAMP_DATA_AW+1:2];
		end
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_DONE = 3'b100;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg tamp_s1_r;
	reg tamp_s2_r;
	reg tamp_prev_r;
	reg wake_s1_r;
	reg wake_s2_r;
	reg armed_r;
	reg armed_nxt;
	reg tamper_event_flag_r;
	reg tamper_event_flag_nxt;
	reg tamper_irq_flag_r;
	reg tamper_irq_flag_nxt;
	reg tamper_irq_enable_r;
	reg tamper_irq_enable_nxt;
	reg [31:0] csr_rd;
	wire access;
	wire wr_commit;
	wire csr_hit;
	wire data_hit;
	wire event_set;
	wire event_clr;
	wire irq_clr;
	wire mem_clr;
	wire [`TAMP_DATA_DW-1:0] mem_rd_data;

	// ------------------------------------------------------------------
	// Synchronisers for tamper level and standby wake
	// ------------------------------------------------------------------
	// Both come from the backup/power domain, so two stages each
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tamp_s1_r <= 1'b0;
			tamp_s2_r <= 1'b0;
			tamp_prev_r <= 1'b0;
			wake_s1_r <= 1'b0;
			wake_s2_r <= 1'b0;
		end else if (ce) begin
			tamp_s1_r <= tamper_detect;
			tamp_s2_r <= tamp_s1_r;
			tamp_prev_r <= tamp_s2_r;
			wake_s1_r <= standby_wake;
			wake_s2_r <= wake_s1_r;
		end
	end

	// ------------------------------------------------------------------
	// Bus decode and event terms
	// ------------------------------------------------------------------
	assign access = psel && penable;
	assign wr_commit = access && pready && pwrite;
	assign csr_hit = (paddr == `TAMP_CSR_OFFSET);
	assign data_hit = is_data(paddr);
	// Edge detect: a level held high is a single event, even after re-arming
	assign event_set = armed_r && tamp_s2_r && !tamp_prev_r;
	assign event_clr = wr_commit && csr_hit &&
		pwdata[`TAMP_EVENT_CLEAR_BIT];
	assign irq_clr = wr_commit && csr_hit &&
		pwdata[`TAMP_IRQ_CLEAR_BIT];
	// Detection itself resets the data, the flag keeps it in reset
	assign mem_clr = event_set || tamper_event_flag_r;

	// ------------------------------------------------------------------
	// Next-state of flags; hardware set wins over software clear
	// ------------------------------------------------------------------
	always @* begin
		// Bit 8 of a CSR write is never looked at
		tamper_event_flag_nxt = event_set ||
			(tamper_event_flag_r && !event_clr);
		// Detection stays blind until software clears the flag
		if (event_set) begin
			armed_nxt = 1'b0;
		end else if (event_clr) begin
			armed_nxt = 1'b1;
		end else begin
			armed_nxt = armed_r;
		end
		tamper_irq_flag_nxt = (event_set && tamper_irq_enable_r) ||
			(tamper_irq_flag_r && !irq_clr);
		if (wr_commit && csr_hit) begin
			tamper_irq_enable_nxt = pwdata[`TAMP_IRQ_ENABLE_BIT];
		end else begin
			tamper_irq_enable_nxt = tamper_irq_enable_r;
		end
		// Standby wake returns enable and irq flag to reset state
		if (wake_s2_r) begin
			tamper_irq_enable_nxt = 1'b0;
			tamper_irq_flag_nxt = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Flag registers
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r <= 1'b1;
			tamper_event_flag_r <= 1'b0;
			tamper_irq_flag_r <= 1'b0;
			tamper_irq_enable_r <= 1'b0;
		end else if (ce) begin
			armed_r <= armed_nxt;
			tamper_event_flag_r <= tamper_event_flag_nxt;
			tamper_irq_flag_r <= tamper_irq_flag_nxt;
			tamper_irq_enable_r <= tamper_irq_enable_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------------
	// Masked while the core sleeps so the line never acts as a wake source
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tamper_irq_r <= 1'b0;
		end else if (ce) begin
			tamper_irq_r <= tamper_irq_flag_nxt && !core_sleep;
		end
	end

	// ------------------------------------------------------------------
	// Control/status read value
	// ------------------------------------------------------------------
	// Clear bits and reserved bits are constant zero
	always @* begin
		csr_rd = 32'h00000000;
		csr_rd[`TAMP_IRQ_ENABLE_BIT] = tamper_irq_enable_r;
		csr_rd[`TAMP_EVENT_FLAG_BIT] = tamper_event_flag_r;
		csr_rd[`TAMP_IRQ_FLAG_BIT] = tamper_irq_flag_r;
	end

	// ------------------------------------------------------------------
	// APB handshake: two wait cycles, registered memory read settled
	// ------------------------------------------------------------------
	always @* begin
		case (state_r)
			ST_IDLE: begin
				state_nxt = access ? ST_WAIT : ST_IDLE;
			end
			ST_WAIT: begin
				state_nxt = ST_DONE;
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (ce) begin
			state_r <= state_nxt;
			pready <= (state_nxt == ST_DONE);
			if (state_nxt == ST_DONE) begin
				pslverr <= !(csr_hit || data_hit);
				if (pwrite) begin
					prdata <= 32'h00000000;
				end else if (csr_hit) begin
					prdata <= csr_rd;
				end else if (data_hit) begin
					prdata <= {16'h0000, mem_rd_data};
				end else begin
					prdata <= 32'h00000000;
				end
			end else begin
				pslverr <= 1'b0;
				prdata <= 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------------
	// Backup data storage
	// ------------------------------------------------------------------
	// Writes land only when the flag is clear; the memory also
	// refuses them itself while clr is high
	backup_data_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clr(mem_clr),
		.wr_en(wr_commit && data_hit && !tamper_event_flag_r),
		.wr_addr(data_index(paddr)),
		.wr_data(pwdata[`TAMP_DATA_DW-1:0]),
		.rd_addr(data_index(paddr)),
		.rd_data_r(mem_rd_data)
	);

endmodule
